/* shared/sclk_pkg.sv */
// Package: constants and types for the segment configuration write lock.
// Assumes a 32-bit Avalon-MM register bus with word addressing by byte offset.
package sclk_pkg;
  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_KEY = 8'h00;
  localparam logic [7:0] ADDR_SEGCFG = 8'h04;
  localparam logic [7:0] ADDR_ACTEN = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_MASK = 8'h10;
  localparam logic [7:0] ADDR_CAUSE = 8'h14;
  // ****************************************************************
  // Codes, fields and reset values
  // ****************************************************************
  localparam logic [7:0] KEY_OPEN = 8'hB5;
  localparam logic [7:0] KEY_CLOSE = 8'hB4;
  localparam int SEG_ACT = 1;
  localparam logic [7:0] SEGCFG_RST = 8'h00;
  localparam logic [7:0] ACTEN_RST = 8'h00;
  localparam logic [1:0] IRQ_RST = 2'h0;
  localparam int IRQ_ILLEGAL = 0;
  localparam int IRQ_REFUSED = 1;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } sclk_state_t;
endpackage

/* shared/sclk_gate_if.sv */
// Interface: write request from the bus slave to the segment lock engine.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ns
interface sclk_gate_if;
  logic wrStb;
  logic [7:0] wrAddr;
  logic [7:0] wrData;
  logic [7:0] segCfg;
  logic keyOpen;
  logic illegalKey;
  logic refused;
  logic [7:0] actEn;
  modport bus (output wrStb, output wrAddr, output wrData,
    input segCfg, input keyOpen, input illegalKey, input refused, input actEn);
  modport core (input wrStb, input wrAddr, input wrData,
    output segCfg, output keyOpen, output illegalKey, output refused, output actEn);
endinterface

/* src/sclk_lock_core.sv */
// Lock engine: key register, segment lock configuration, segment 1 template.
// Assumes write strobes arrive one cycle long from the bus slave.
`timescale 1ns/1ns
module sclk_lock_core (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Slave side
  sclk_gate_if.core gate
);
  typedef struct packed {
    logic keyOpen;
    logic [7:0] segCfg;
    logic [7:0] actEn;
    logic illegalKey;
    logic refused;
  } sclk_core_t;
  sclk_core_t st_reg;
  sclk_core_t st_next;
  logic [7:0] cfgMerge;
  // ****************************************************************
  // Per segment lock and protect update
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gSeg
      always_comb begin
        cfgMerge[2*g+1] = st_reg.segCfg[2*g+1] | gate.wrData[2*g+1];
        if (st_reg.segCfg[2*g+1]) begin
          cfgMerge[2*g] = st_reg.segCfg[2*g];
        end else begin
          cfgMerge[2*g] = gate.wrData[2*g];
        end
      end
    end
  endgenerate
  always_comb begin
    st_next = st_reg;
    st_next.illegalKey = 1'b0;
    st_next.refused = 1'b0;
    if (gate.wrStb) begin
      case (gate.wrAddr)
        sclk_pkg::ADDR_KEY: begin
          if (gate.wrData == sclk_pkg::KEY_OPEN) begin
            st_next.keyOpen = 1'b1;
          end else if (gate.wrData == sclk_pkg::KEY_CLOSE) begin
            st_next.keyOpen = 1'b0;
          end else begin
            st_next.illegalKey = 1'b1;
            st_next.keyOpen = 1'b0;
          end
        end
        sclk_pkg::ADDR_SEGCFG: begin
          if (st_reg.keyOpen) begin
            st_next.segCfg = cfgMerge;
          end
        end
        sclk_pkg::ADDR_ACTEN: begin
          if (!st_reg.segCfg[2*sclk_pkg::SEG_ACT]) begin
            st_next.actEn = gate.wrData;
          end else begin
            st_next.refused = 1'b1;
          end
        end
        default: begin
          st_next = st_next;
        end
      endcase
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_reg <= '{keyOpen: 1'b0, segCfg: sclk_pkg::SEGCFG_RST, actEn: sclk_pkg::ACTEN_RST,
                  illegalKey: 1'b0, refused: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end
  assign gate.segCfg = st_reg.segCfg;
  assign gate.keyOpen = st_reg.keyOpen;
  assign gate.illegalKey = st_reg.illegalKey;
  assign gate.refused = st_reg.refused;
  assign gate.actEn = st_reg.actEn;
  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_protect_sticky: assert property (@(posedge mclk) disable iff (reset)
    st_reg.segCfg[3] |=> st_reg.segCfg[3]) else $error("protect bit cleared");
  chk_lock_frozen: assert property (@(posedge mclk) disable iff (reset)
    st_reg.segCfg[3] |=> $stable(st_reg.segCfg[2])) else $error("protected lock moved");
  chk_closed_cfg: assert property (@(posedge mclk) disable iff (reset)
    !st_reg.keyOpen |=> $stable(st_reg.segCfg)) else $error("closed key let write");
  chk_locked_template: assert property (@(posedge mclk) disable iff (reset)
    st_reg.segCfg[2] |=> $stable(st_reg.actEn)) else $error("locked segment written");
  chk_key_open: assert property (@(posedge mclk) disable iff (reset)
    gate.wrStb && gate.wrAddr == sclk_pkg::ADDR_KEY && gate.wrData == sclk_pkg::KEY_OPEN
    |=> st_reg.keyOpen) else $error("open code ignored");
  chk_key_close: assert property (@(posedge mclk) disable iff (reset)
    gate.wrStb && gate.wrAddr == sclk_pkg::ADDR_KEY && gate.wrData == sclk_pkg::KEY_CLOSE
    |=> !st_reg.keyOpen) else $error("close code ignored");
  cov_open: cover property (@(posedge mclk) disable iff (reset)
    !st_reg.keyOpen ##1 st_reg.keyOpen);
  cov_protect: cover property (@(posedge mclk) disable iff (reset)
    !st_reg.segCfg[3] ##1 st_reg.segCfg[3]);
endmodule

/* src/sclk_top.sv */
// Top: Avalon-MM slave, interrupt status and reset request for the lock engine.
// Assumes a synchronous active-high reset and a master that holds requests.
`timescale 1ns/1ns
// Notes on behaviour
// - Code B5 opens segment config writes
// - Code B4 closes segment config writes
// - Bit 2 locks segment 1 writes
// - Bit 3 freezes segment 1 lock
// - Peripheral enable template is segment 1
// - Other key codes reset, set flag
// - Reset closes key; closed segment config writes ignored
// - Protect bits set once, reset clears
// - Eight bits: lock, protect per segment
module sclk_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // System
  output logic segResetReq,
  output logic [7:0] activePeripheralEnable,
  output logic irq
);
  typedef struct packed {
    sclk_pkg::sclk_state_t state;
    logic [31:0] rdata;
    logic waitReq;
    logic wrStb;
    logic [7:0] wrAddr;
    logic [7:0] wrData;
    logic [1:0] status;
    logic [1:0] mask;
    logic illegalKeyResetFlag;
    logic resetReq;
    logic irq;
    logic [7:0] actEn;
  } sclk_top_t;
  sclk_top_t st_reg;
  sclk_top_t st_next;
  sclk_gate_if gate ();
  // ****************************************************************
  // Lock engine
  // ****************************************************************
  sclk_lock_core u_core (
    .mclk(mclk),
    .reset(reset),
    .gate(gate.core)
  );
  assign gate.wrStb = st_reg.wrStb;
  assign gate.wrAddr = st_reg.wrAddr;
  assign gate.wrData = st_reg.wrData;
  // ****************************************************************
  // Bus slave, status and interrupt
  // ****************************************************************
  always_comb begin
    logic [1:0] evt;
    logic [1:0] clr;
    evt = 2'h0;
    clr = 2'h0;
    st_next = st_reg;
    st_next.wrStb = 1'b0;
    st_next.resetReq = 1'b0;
    st_next.actEn = gate.actEn;
    evt[sclk_pkg::IRQ_ILLEGAL] = gate.illegalKey;
    evt[sclk_pkg::IRQ_REFUSED] = gate.refused;
    if (gate.illegalKey) begin
      st_next.illegalKeyResetFlag = 1'b1;
      st_next.resetReq = 1'b1;
    end
    case (st_reg.state)
      sclk_pkg::ST_IDLE: begin
        if (read || write) begin
          st_next.state = sclk_pkg::ST_WAIT;
          st_next.wrStb = write;
          st_next.wrAddr = address;
          st_next.wrData = writedata[7:0];
        end
      end
      sclk_pkg::ST_WAIT: begin
        st_next.state = sclk_pkg::ST_DONE;
        st_next.waitReq = 1'b0;
        case (st_reg.wrAddr)
          sclk_pkg::ADDR_KEY: st_next.rdata = {24'h00_0000, 7'h00, gate.keyOpen};
          sclk_pkg::ADDR_SEGCFG: st_next.rdata = {24'h00_0000, gate.segCfg};
          sclk_pkg::ADDR_ACTEN: st_next.rdata = {24'h00_0000, gate.actEn};
          sclk_pkg::ADDR_STATUS: st_next.rdata = {30'h0000_0000, st_reg.status};
          sclk_pkg::ADDR_MASK: st_next.rdata = {30'h0000_0000, st_reg.mask};
          sclk_pkg::ADDR_CAUSE: st_next.rdata = {31'h0000_0000, st_reg.illegalKeyResetFlag};
          default: st_next.rdata = sclk_pkg::UNMAPPED_DATA;
        endcase
        if (write) begin
          if (address == sclk_pkg::ADDR_STATUS) begin
            clr = writedata[1:0];
          end
          if (address == sclk_pkg::ADDR_MASK) begin
            st_next.mask = writedata[1:0];
          end
          if (address == sclk_pkg::ADDR_CAUSE && writedata[0]) begin
            st_next.illegalKeyResetFlag = gate.illegalKey;
          end
        end
      end
      sclk_pkg::ST_DONE: begin
        st_next.state = sclk_pkg::ST_IDLE;
        st_next.waitReq = 1'b1;
      end
      default: begin
        st_next.state = sclk_pkg::ST_IDLE;
        st_next.waitReq = 1'b1;
      end
    endcase
    st_next.status = (st_reg.status & ~clr) | evt;
    st_next.irq = |(st_next.status & st_next.mask);
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_reg <= '{state: sclk_pkg::ST_IDLE, rdata: sclk_pkg::UNMAPPED_DATA, waitReq: 1'b1,
                  wrStb: 1'b0, wrAddr: sclk_pkg::ADDR_KEY, wrData: 8'h00,
                  status: sclk_pkg::IRQ_RST, mask: sclk_pkg::IRQ_RST,
                  illegalKeyResetFlag: 1'b0, resetReq: 1'b0, irq: 1'b0,
                  actEn: sclk_pkg::ACTEN_RST};
    end else begin
      st_reg <= st_next;
    end
  end
  assign readdata = st_reg.rdata;
  assign waitrequest = st_reg.waitReq;
  assign segResetReq = st_reg.resetReq;
  assign activePeripheralEnable = st_reg.actEn;
  assign irq = st_reg.irq;
  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_bus_answer: assert property (@(posedge mclk) disable iff (reset)
    (st_reg.state == sclk_pkg::ST_IDLE) && (read || write) |=> waitrequest ##1 !waitrequest)
    else $error("answer not in two cycles");
  chk_illegal_reset: assert property (@(posedge mclk) disable iff (reset)
    gate.illegalKey |=> segResetReq && st_reg.illegalKeyResetFlag)
    else $error("illegal key without reset");
  chk_irq_level: assert property (@(posedge mclk) disable iff (reset)
    (gate.illegalKey && st_reg.mask[sclk_pkg::IRQ_ILLEGAL]) ||
    (gate.refused && st_reg.mask[sclk_pkg::IRQ_REFUSED]) |=> irq)
    else $error("irq low after unmasked event");
  cov_illegal: cover property (@(posedge mclk) disable iff (reset) segResetReq);
  cov_write: cover property (@(posedge mclk) disable iff (reset) write && !waitrequest);
endmodule

/* bench/tb.sv */
// Testbench for the segment configuration write lock top module.
// Assumes the design files and shared package are compiled first.
`timescale 1ns/1ns
module tb;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata;
  logic waitrequest;
  logic segResetReq;
  logic [7:0] activePeripheralEnable;
  logic irq;
  int numErrors = 0;
  int nTests = 0;
  int nPulse = 0;

  always #10 mclk = ~mclk;

  sclk_top dut (
    .mclk(mclk),
    .reset(reset),
    .address(address),
    .read(read),
    .write(write),
    .writedata(writedata),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .segResetReq(segResetReq),
    .activePeripheralEnable(activePeripheralEnable),
    .irq(irq)
  );

  // Counts device reset pulses
  always @(posedge mclk) begin
    if (segResetReq === 1'b1) begin
      nPulse <= nPulse + 1;
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic summarize();
    $display("errors %0d, comparisons %0d", numErrors, nTests);
    if (numErrors == 0 && nTests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic checkWord(input logic [31:0] got, input logic [31:0] exp, input string what);
    nTests++;
    if (got !== exp) begin
      numErrors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic checkBit(input logic got, input logic exp, input string what);
    nTests++;
    if (got !== exp) begin
      numErrors++;
      $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask

  // One bus access; called right after a rising edge
  task automatic busXfer(input logic [7:0] a, input logic rd, input logic [31:0] d,
                         output logic [31:0] q);
    address <= a;
    read <= rd;
    write <= !rd;
    writedata <= d;
    do begin
      @(posedge mclk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    busXfer(a, 1'b0, d, q);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    busXfer(a, 1'b1, 32'h0000_0000, q);
    checkWord(q, exp, "read data");
  endtask

  task automatic hwReset();
    reset <= 1'b1;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    hwReset();
    rdChk(sclk_pkg::ADDR_KEY, 32'h0000_0000);
    rdChk(sclk_pkg::ADDR_SEGCFG, 32'h0000_0000);
    rdChk(sclk_pkg::ADDR_ACTEN, 32'h0000_0000);
    rdChk(sclk_pkg::ADDR_CAUSE, 32'h0000_0000);
    rdChk(8'h18, sclk_pkg::UNMAPPED_DATA);
    wr(sclk_pkg::ADDR_SEGCFG, 32'h0000_00FF);
    rdChk(sclk_pkg::ADDR_SEGCFG, 32'h0000_0000);
    wr(sclk_pkg::ADDR_ACTEN, 32'h0000_005A);
    rdChk(sclk_pkg::ADDR_ACTEN, 32'h0000_005A);
    $display("test reset_closed done");
    wr(sclk_pkg::ADDR_KEY, {24'h00_0000, sclk_pkg::KEY_OPEN});
    rdChk(sclk_pkg::ADDR_KEY, 32'h0000_0001);
    wr(sclk_pkg::ADDR_SEGCFG, 32'h0000_0004);
    rdChk(sclk_pkg::ADDR_SEGCFG, 32'h0000_0004);
    wr(sclk_pkg::ADDR_ACTEN, 32'h0000_0033);
    rdChk(sclk_pkg::ADDR_ACTEN, 32'h0000_005A);
    checkWord({24'h00_0000, activePeripheralEnable}, 32'h0000_005A, "template");
    rdChk(sclk_pkg::ADDR_STATUS, 32'h0000_0002);
    checkBit(irq, 1'b0, "irq masked");
    wr(sclk_pkg::ADDR_MASK, 32'h0000_0002);
    checkBit(irq, 1'b1, "irq raised");
    wr(sclk_pkg::ADDR_STATUS, 32'h0000_0002);
    checkBit(irq, 1'b0, "irq cleared");
    $display("test lock_refuse done");
    wr(sclk_pkg::ADDR_KEY, {24'h00_0000, sclk_pkg::KEY_OPEN});
    wr(sclk_pkg::ADDR_SEGCFG, 32'h0000_0000);
    wr(sclk_pkg::ADDR_ACTEN, 32'h0000_00C3);
    wr(sclk_pkg::ADDR_SEGCFG, 32'h0000_0004);
    wr(sclk_pkg::ADDR_KEY, {24'h00_0000, sclk_pkg::KEY_CLOSE});
    checkWord({24'h00_0000, activePeripheralEnable}, 32'h0000_00C3, "template");
    rdChk(sclk_pkg::ADDR_KEY, 32'h0000_0000);
    wr(sclk_pkg::ADDR_SEGCFG, 32'h0000_0000);
    rdChk(sclk_pkg::ADDR_SEGCFG, 32'h0000_0004);
    $display("test reconfigure done");
    wr(sclk_pkg::ADDR_KEY, {24'h00_0000, sclk_pkg::KEY_OPEN});
    wr(sclk_pkg::ADDR_SEGCFG, 32'h0000_000C);
    wr(sclk_pkg::ADDR_SEGCFG, 32'h0000_0001);
    rdChk(sclk_pkg::ADDR_SEGCFG, 32'h0000_000D);
    $display("test protect done");
    wr(sclk_pkg::ADDR_MASK, 32'h0000_0001);
    wr(sclk_pkg::ADDR_KEY, 32'h0000_0077);
    rdChk(sclk_pkg::ADDR_CAUSE, 32'h0000_0001);
    checkWord(32'(nPulse), 32'h0000_0001, "reset pulses");
    rdChk(sclk_pkg::ADDR_KEY, 32'h0000_0000);
    checkBit(irq, 1'b1, "irq illegal key");
    wr(sclk_pkg::ADDR_CAUSE, 32'h0000_0001);
    rdChk(sclk_pkg::ADDR_CAUSE, 32'h0000_0000);
    $display("test illegal_key done");
    hwReset();
    rdChk(sclk_pkg::ADDR_SEGCFG, 32'h0000_0000);
    checkBit(irq, 1'b0, "irq after reset");
    $display("test hard_reset done");
    summarize();
  end

  // Watchdog
  initial begin
    #200000;
    numErrors++;
    summarize();
  end
endmodule
